/* File: logic/anp_pkg.sv */
// constants shared by both ends of the next-page exchange
package anp_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_LP_BASE = 6'h05;
  localparam logic [5:0] IDX_EXP     = 6'h06;
  localparam logic [5:0] IDX_NPT     = 6'h07;
  localparam logic [5:0] IDX_LP_NP   = 6'h08;
  localparam logic [5:0] IDX_CFG     = 6'h10;

  // ----------------------------------------------------------------
  // link code word fields
  // ----------------------------------------------------------------
  localparam int BIT_MORE = 15;
  localparam int BIT_ACK  = 14;
  localparam int BIT_MSG  = 13;
  localparam int BIT_SECOND_ACKNOWLEDGE = 12;
  localparam int BIT_TGL  = 11;

  // ----------------------------------------------------------------
  // expansion status and configuration fields
  // ----------------------------------------------------------------
  localparam int EXP_BASE  = 5;
  localparam int EXP_PDF   = 4;
  localparam int EXP_LPNPA = 3;
  localparam int EXP_NPA   = 2;
  localparam int EXP_PRX   = 1;
  localparam int EXP_LPANA = 0;
  localparam int CFG_ALTNP = 1;
  localparam int CFG_TXDIS = 13;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] NPT_RESET = 16'h2001;
  localparam logic [15:0] NPT_WMASK = 16'hBFFF;
  localparam logic [15:0] CFG_WMASK = 16'h2002;
  localparam logic [15:0] ZERO16    = 16'h0000;
  localparam logic        NPA_LOCAL = 1'b1;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  function automatic logic [5:0] anp_index(input logic [31:0] addr);
    anp_index = addr[7:2];
  endfunction

endpackage

/* File: logic/anp_link_if.sv */
// link between the local register bank and the remote partner logic
`timescale 1ns/1ps
interface anp_link_if;
  logic [15:0] dv_word;
  logic        dv_stb;
  logic [15:0] lp_word;
  logic        lp_stb;
  logic        lp_base;
  logic        lp_an_able;
  logic        pd_fault;

  modport device (
    output dv_word,
    output dv_stb,
    input  lp_word,
    input  lp_stb,
    input  lp_base,
    input  lp_an_able,
    input  pd_fault
  );

  modport partner (
    input  dv_word,
    input  dv_stb,
    output lp_word,
    output lp_stb,
    output lp_base,
    output lp_an_able,
    output pd_fault
  );
endinterface

/* File: logic/anp_device.sv */
// local next-page register bank with AHB-Lite slave and link end
//
// Behaviour
// - base-page flag mirrors base_page when enabled
// - base-page flag tracks exchange synchronisation
// - fault bit latches high until read
// - report partner next-page ability read-only
// - local next-page able reads one
// - new page loads register, sets received flag
// - reading expansion clears page-received flag
// - alt mode clears flag on idle/disable
// - report partner autoneg ability read-only
// - management sets more-pages until last page
// - transmit bit 14 reads zero
// - message-page bit writable, resets to one
// - management sets second-acknowledge per compliance
// - toggle inverts previous transmitted toggle
// - partner more-pages bit read-only
// - partner acknowledge bit read-only
// - partner message-page bit read-only
// - partner second-acknowledge bit read-only
// - next pages go to next-page register
// - alternate feature enable bit, reset zero
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module anp_device
  import anp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  anp_link_if.device       link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        wr_pend_ff;
  logic [5:0]  wr_idx_ff;
  logic [15:0] cfg_ff;
  logic [15:0] npt_ff;
  logic        npt_pend_ff;
  logic [15:0] lp_base_ff;
  logic [15:0] lp_np_ff;
  logic        mr_page_rx_ff;
  logic        base_page_ff;
  logic        page_rx_ff;
  logic        pdf_ff;
  logic        lp_ana_ff;
  logic [15:0] dv_word_ff;
  logic        dv_stb_ff;

  logic        addr_ok;
  logic        rd_req;
  logic        wr_req;
  logic [5:0]  req_idx;
  logic        exp_read;
  logic        wr_npt;
  logic        wr_cfg;
  logic        alt_np;
  logic        tx_dis;
  logic        tx_fire;
  logic [15:0] exp_val;
  logic [15:0] rd_val;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // size is not checked: only whole-word transfers are expected
  assign addr_ok  = hsel && hready && htrans[1];
  assign rd_req   = addr_ok && !hwrite;
  assign wr_req   = addr_ok && hwrite;
  assign req_idx  = anp_index(haddr);
  assign exp_read = rd_req && (req_idx == IDX_EXP);
  assign wr_npt   = wr_pend_ff && (wr_idx_ff == IDX_NPT);
  assign wr_cfg   = wr_pend_ff && (wr_idx_ff == IDX_CFG);
  assign alt_np   = cfg_ff[CFG_ALTNP];
  assign tx_dis   = cfg_ff[CFG_TXDIS];

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  always_comb begin
    exp_val            = ZERO16;
    exp_val[EXP_BASE]  = alt_np && base_page_ff;
    exp_val[EXP_PDF]   = pdf_ff;
    exp_val[EXP_LPNPA] = lp_base_ff[BIT_MORE];
    exp_val[EXP_NPA]   = NPA_LOCAL;
    exp_val[EXP_PRX]   = page_rx_ff;
    exp_val[EXP_LPANA] = lp_ana_ff;
  end

  always_comb begin
    unique case (req_idx)
      IDX_LP_BASE: rd_val = lp_base_ff;
      IDX_EXP:     rd_val = exp_val;
      IDX_NPT:     rd_val = npt_ff;
      IDX_LP_NP:   rd_val = lp_np_ff;
      IDX_CFG:     rd_val = cfg_ff;
      default:     rd_val = ZERO16;
    endcase
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
      if (rd_req) begin
        hrdata_ff <= {ZERO16, rd_val};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 6'h00;
    end else begin
      wr_pend_ff <= wr_req;
      if (wr_req) begin
        wr_idx_ff <= req_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= ZERO16;
    end else if (wr_cfg) begin
      cfg_ff <= hwdata[15:0] & CFG_WMASK;
    end
  end

  // toggle follows the word actually sent, so a write in the
  // same cycle as a send loses only its toggle bit to hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      npt_ff <= NPT_RESET;
    end else if (tx_fire && wr_npt) begin
      npt_ff          <= hwdata[15:0] & NPT_WMASK;
      npt_ff[BIT_TGL] <= ~npt_ff[BIT_TGL];
    end else if (tx_fire) begin
      npt_ff[BIT_TGL] <= ~npt_ff[BIT_TGL];
    end else if (wr_npt) begin
      npt_ff <= hwdata[15:0] & NPT_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      npt_pend_ff <= 1'b0;
    end else if (wr_npt) begin
      npt_pend_ff <= 1'b1;
    end else if (tx_fire) begin
      npt_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // received pages
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_base_ff <= ZERO16;
      lp_np_ff   <= ZERO16;
    end else if (link.lp_stb) begin
      if (link.lp_base) begin
        lp_base_ff <= link.lp_word;
      end else begin
        lp_np_ff <= link.lp_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_page_ff <= 1'b0;
    end else if (link.lp_stb) begin
      base_page_ff <= link.lp_base;
    end
  end

  // partner page waiting for a local answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mr_page_rx_ff <= 1'b0;
    end else if (link.lp_stb) begin
      mr_page_rx_ff <= 1'b1;
    end else if (tx_fire) begin
      mr_page_rx_ff <= 1'b0;
    end
  end

  // set wins over every clear so no page event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_rx_ff <= 1'b0;
    end else if (link.lp_stb) begin
      page_rx_ff <= 1'b1;
    end else if (exp_read) begin
      page_rx_ff <= 1'b0;
    end else if (alt_np && (!mr_page_rx_ff || tx_dis)) begin
      page_rx_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdf_ff <= 1'b0;
    end else if (link.pd_fault) begin
      pdf_ff <= 1'b1;
    end else if (exp_read) begin
      pdf_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_ana_ff <= 1'b0;
    end else begin
      lp_ana_ff <= link.lp_an_able;
    end
  end

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  // only answers a partner page; transmitter disable blocks sends
  assign tx_fire = npt_pend_ff && mr_page_rx_ff && !tx_dis;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_word_ff <= ZERO16;
      dv_stb_ff  <= 1'b0;
    end else begin
      dv_stb_ff <= tx_fire;
      if (tx_fire) begin
        dv_word_ff          <= npt_ff;
        dv_word_ff[BIT_ACK] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata       = hrdata_ff;
  assign hreadyout    = hreadyout_ff;
  assign hresp        = HRESP_OKAY[0];
  assign link.dv_word = dv_word_ff;
  assign link.dv_stb  = dv_stb_ff;

endmodule

/* File: logic/anp_partner.sv */
// remote partner end of the next-page exchange
`timescale 1ns/1ps
module anp_partner
  import anp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  anp_link_if.partner      link,
  input  wire logic [15:0] base_word,
  input  wire logic [15:0] next_word,
  input  wire logic        an_able,
  input  wire logic        start,
  input  wire logic        fault,
  output logic [15:0]      rx_word,
  output logic             rx_stb
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] lp_word_ff;
  logic        lp_stb_ff;
  logic        lp_base_ff;
  logic        an_able_ff;
  logic        fault_ff;
  logic        tgl_ff;
  logic        last_more_ff;
  logic [15:0] rx_word_ff;
  logic        rx_stb_ff;
  logic        reply;

  // exchange keeps going while either side still has pages
  assign reply = link.dv_stb && (link.dv_word[BIT_MORE] || last_more_ff);

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_word_ff   <= ZERO16;
      lp_stb_ff    <= 1'b0;
      lp_base_ff   <= 1'b0;
      tgl_ff       <= 1'b0;
      last_more_ff <= 1'b0;
    end else begin
      lp_stb_ff <= start || reply;
      if (start) begin
        lp_word_ff   <= base_word;
        lp_base_ff   <= 1'b1;
        tgl_ff       <= 1'b0;
        last_more_ff <= base_word[BIT_MORE];
      end else if (reply) begin
        lp_word_ff          <= next_word;
        lp_word_ff[BIT_ACK] <= 1'b1;
        lp_word_ff[BIT_TGL] <= tgl_ff;
        lp_base_ff          <= 1'b0;
        tgl_ff              <= ~tgl_ff;
        last_more_ff        <= next_word[BIT_MORE];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_able_ff <= 1'b0;
      fault_ff   <= 1'b0;
    end else begin
      an_able_ff <= an_able;
      fault_ff   <= fault;
    end
  end

  // ----------------------------------------------------------------
  // receive
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_word_ff <= ZERO16;
      rx_stb_ff  <= 1'b0;
    end else begin
      rx_stb_ff <= link.dv_stb;
      if (link.dv_stb) begin
        rx_word_ff <= link.dv_word;
      end
    end
  end

  assign link.lp_word    = lp_word_ff;
  assign link.lp_stb     = lp_stb_ff;
  assign link.lp_base    = lp_base_ff;
  assign link.lp_an_able = an_able_ff;
  assign link.pd_fault   = fault_ff;
  assign rx_word         = rx_word_ff;
  assign rx_stb          = rx_stb_ff;

endmodule

/* File: tb/anp_link_chk.sv */
// assertions on the link between the local bank and the partner end
`timescale 1ns/1ps
module anp_link_chk
  import anp_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [15:0] dv_word,
  input wire logic        dv_stb,
  input wire logic [15:0] lp_word,
  input wire logic        lp_stb,
  input wire logic        lp_base,
  input wire logic        lp_an_able,
  input wire logic        pd_fault
);
  logic pend_ff;
  logic ptgl_ff;
  logic dtgl_ff;
  logic sent_ff;

  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  // page arrival wins over send, as in the bank itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pend_ff <= 1'b0;
    else if (lp_stb) pend_ff <= 1'b1;
    else if (dv_stb) pend_ff <= 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ptgl_ff <= 1'b0;
    else if (lp_stb) ptgl_ff <= lp_base ? 1'b0 : ~ptgl_ff;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent_ff <= 1'b0;
      dtgl_ff <= 1'b0;
    end else if (dv_stb) begin
      sent_ff <= 1'b1;
      dtgl_ff <= dv_word[BIT_TGL];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_send_one_cycle: assert property (dv_stb |=> !dv_stb)
    else $error("send strobe longer than one cycle");
  chk_send_ack_set: assert property (dv_stb |-> dv_word[BIT_ACK])
    else $error("sent word lacks acknowledge");
  chk_word_holds: assert property (!dv_stb |-> $stable(dv_word))
    else $error("sent word changed without a send");
  chk_send_after_page: assert property (dv_stb |-> pend_ff)
    else $error("send without a waiting partner page");
  chk_reply_next: assert property (
    dv_stb && dv_word[BIT_MORE] |=> lp_stb && !lp_base && lp_word[BIT_ACK])
    else $error("partner did not answer with a next page");
  chk_lp_tgl_alt: assert property (
    lp_stb && !lp_base |-> lp_word[BIT_TGL] == ptgl_ff)
    else $error("partner toggle did not alternate");
  chk_dv_tgl_alt: assert property (
    dv_stb && sent_ff |-> dv_word[BIT_TGL] != dtgl_ff)
    else $error("sent toggle did not alternate");
  chk_reply_timing: assert property (lp_stb && !lp_base |-> $past(dv_stb))
    else $error("next page without a preceding send");

  cov_send: cover property (dv_stb);
  cov_base: cover property (lp_stb && lp_base);
  cov_fault: cover property (pd_fault && lp_an_able);
endmodule

/* File: tb/anp_tb_top.sv */
// self-checking bench joining the bank and the partner end
`timescale 1ns/1ps
module anp_tb_top;
  import anp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic        start, fault, an_able, rx_stb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] base_word, next_word, rx_word;
  int          n_mismatch, n_checks;

  anp_link_if link ();
  anp_device u_anp_device (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp));
  anp_partner u_anp_partner (.hclk(hclk), .hresetn(hresetn), .link(link),
    .base_word(base_word), .next_word(next_word), .an_able(an_able), .start(start),
    .fault(fault), .rx_word(rx_word), .rx_stb(rx_stb));
  anp_link_chk u_anp_link_chk (.hclk(hclk), .hresetn(hresetn), .dv_word(link.dv_word),
    .dv_stb(link.dv_stb), .lp_word(link.lp_word), .lp_stb(link.lp_stb),
    .lp_base(link.lp_base), .lp_an_able(link.lp_an_able), .pd_fault(link.pd_fault));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // waits end when hready is high; a stuck wait ends only through the watchdog, never by a cycle count
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, e, input string nm);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    cmp(nm, e, r);
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic pulse_start();
    @(posedge hclk);
    start <= 1'b1;
    @(posedge hclk);
    start <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(32'h18, 32'h4, "exp reset");
    rd(32'h1C, 32'h2001, "npt reset");
    rd(32'h20, 32'h0, "lp np reset");
    rd(32'h40, 32'h0, "cfg reset");
    wr(32'h18, 32'hFFFF);
    rd(32'h18, 32'h4, "exp ro write");
    rd(32'h30, 32'h0, "unmapped");
    wr(32'h1C, 32'hFFFF);
    rd(32'h1C, 32'hBFFF, "npt bit14");
    wr(32'h1C, 32'hF005);
    rd(32'h1C, 32'hB005, "npt fields");
  endtask

  // base page answered from the pending register, then one next page back
  task automatic t_exchange();
    an_able <= 1'b1;
    pulse_start();
    @(posedge hclk iff rx_stb === 1'b1);
    cmp("sent word", 32'hF005, {16'h0, rx_word});
    repeat (3) @(posedge hclk);
    rd(32'h18, 32'hF, "exp page");
    rd(32'h18, 32'hD, "exp cleared");
    rd(32'h14, 32'h8001, "lp base");
    rd(32'h20, 32'h7123, "lp next");
    rd(32'h1C, 32'hB805, "npt toggle");
  endtask

  task automatic t_alt();
    wr(32'h40, 32'h2);
    rd(32'h40, 32'h2, "cfg alt");
    pulse_start();
    repeat (4) @(posedge hclk);
    wr(32'h40, 32'h2002);
    rd(32'h18, 32'h2D, "exp txdis");
    wr(32'h40, 32'h2);
    @(posedge hclk);
    fault <= 1'b1;
    @(posedge hclk);
    fault <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(32'h18, 32'h3D, "exp fault");
    rd(32'h18, 32'h2D, "exp base");
    wr(32'h1C, 32'h2806);
    @(posedge hclk iff rx_stb === 1'b1);
    cmp("last word", 32'h6806, {16'h0, rx_word});
    rd(32'h18, 32'hF, "exp next alt");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    start      = 1'b0;
    fault      = 1'b0;
    an_able    = 1'b0;
    base_word  = 16'h8001;
    next_word  = 16'h3123;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_exchange();
    t_alt();
    conclude();
  end
endmodule
